/* dv/hbsm_host_model.sv */
// Host processor bus model: single 16-bit accesses ended by acknowledge
`timescale 1ns/1ps
module hbsm_host_model (
    // Clocking
    input wire logic clk,
    // Device answers
    input wire logic transferAck,
    input wire logic [15:0] hostDataOut,
    // Host drives
    output logic chipSel_n,
    output logic [16:0] hostAddr,
    output logic [15:0] hostDataIn,
    output logic lowByteWriteStrobe_n,
    output logic highByteWriteStrobe_n,
    output logic lowByteReadStrobe_n,
    output logic highByteReadStrobe_n
);
    // ****************
    // Access sequence
    // ****************
    initial
    begin
        chipSel_n = 1'b1;
        hostAddr = '1;
        hostDataIn = '1;
        {highByteWriteStrobe_n, lowByteWriteStrobe_n} = 2'b11;
        {highByteReadStrobe_n, lowByteReadStrobe_n} = 2'b11;
    end

    task automatic access(input logic wr, input logic [16:0] a, input logic [15:0] wd,
        input logic [1:0] lanes, output logic [15:0] rd, output logic ok);
        int n;
        ok = 1'b0;
        rd = '0;
        @(negedge clk);
        hostAddr = a;
        hostDataIn = wd;
        @(posedge clk);
        chipSel_n <= 1'b0; // Select half a clock after address
        @(negedge clk);
        {highByteWriteStrobe_n, lowByteWriteStrobe_n} = wr ? ~lanes : 2'b11;
        {highByteReadStrobe_n, lowByteReadStrobe_n} = wr ? 2'b11 : ~lanes;
        for (n = 0; n < 40 && !ok; n++)
        begin
            @(posedge clk);
            // No fixed wait count: end on acknowledge, or give up after 40 cycles
            if (transferAck === 1'b1)
            begin
                ok = 1'b1;
                rd = hostDataOut;
            end
        end
        @(negedge clk);
        {highByteWriteStrobe_n, lowByteWriteStrobe_n} = 2'b11;
        {highByteReadStrobe_n, lowByteReadStrobe_n} = 2'b11;
        chipSel_n = 1'b1;
        hostAddr = ~a;
        hostDataIn = ~wd;
        // Uncached single accesses, strictly in order
        repeat (4) @(negedge clk);
    endtask : access
endmodule : hbsm_host_model

/* dv/hbsm_host_port_test.sv */
// Self-checking bench of the host port: straps, map, stall and registers
`timescale 1ns/1ps
module hbsm_host_port_test;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic refreshBusy = 1'b0;
    logic clkEn = 1'b1;
    logic [4:0] strapPins = 5'h0E;
    logic [15:0] hostDataOut, hostDataIn, rd;
    logic [16:0] hostAddr;
    logic chipSel_n, transferAck, transferAckOe, hostDataOe, bigEndian, genericMode, ok;
    logic lowByteWriteStrobe_n, highByteWriteStrobe_n, lowByteReadStrobe_n;
    logic highByteReadStrobe_n;
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    int t0 = 0;
    int ackCyc = 0;

    // ****************
    // Design and host
    // ****************
    hbsm_host_port #(.REV_CODE(8'h3C)) dut ( // Arbitrary revision value
        .clk, .rst_b, .clkEn,
        .byteOrderStrap(strapPins[4]), .busSelectStrap2(strapPins[3]),
        .busSelectStrap1(strapPins[2]), .busSelectStrap0(strapPins[1]),
        .busStartStrap_n(strapPins[0]), .chipSel_n, .hostAddr, .hostDataIn, .hostDataOut,
        .hostDataOe, .lowByteWriteStrobe_n, .highByteWriteStrobe_n, .lowByteReadStrobe_n,
        .highByteReadStrobe_n, .transferAck, .transferAckOe, .refreshBusy, .bigEndian,
        .genericMode);
    hbsm_host_model host (.clk, .transferAck, .hostDataOut, .chipSel_n, .hostAddr,
        .hostDataIn, .lowByteWriteStrobe_n, .highByteWriteStrobe_n, .lowByteReadStrobe_n,
        .highByteReadStrobe_n);

    initial
    begin
        forever #5 clk = ~clk; // Host bus clock
    end

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (transferAck === 1'b1)
            ackCyc <= cyc;
        if (cyc == 20000)
        begin
            failures++;
            finish_test();
        end
    end

    // ****************
    // Tasks
    // ****************
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic reset_with(input logic [4:0] s);
        @(negedge clk);
        strapPins = s;
        rst_b = 1'b0;
        repeat (10) @(negedge clk);
        chk("reset outputs", 16'h0000,
            16'({transferAck, transferAckOe, hostDataOe, bigEndian, genericMode}));
        chk("reset data", 16'h0000, hostDataOut);
        rst_b = 1'b1;
        repeat (8) @(negedge clk);
    endtask : reset_with

    task automatic test_straps;
        reset_with(5'b0_111_0);
        chk("bigEndian", 16'h0000, 16'(bigEndian));
        chk("genericMode", 16'h0001, 16'(genericMode));
        strapPins = 5'b1_000_1;
        repeat (6) @(negedge clk);
        chk("frozen straps", 16'h0001, 16'({bigEndian, genericMode}));
    endtask : test_straps

    task automatic test_memory;
        host.access(1'b1, 17'h00000, 16'hA55A, 2'b11, rd, ok);
        host.access(1'b1, 17'h13FFE, 16'h0F1E, 2'b11, rd, ok);
        host.access(1'b1, 17'h00000, 16'hFF77, 2'b01, rd, ok);
        host.access(1'b0, 17'h00000, 16'h0000, 2'b11, rd, ok);
        chk("low lane write", 16'hA577, rd);
        host.access(1'b0, 17'h13FFE, 16'h0000, 2'b11, rd, ok);
        chk("top memory word", 16'h0F1E, rd);
        host.access(1'b1, 17'h14000, 16'h1234, 2'b11, rd, ok);
        host.access(1'b0, 17'h14000, 16'h0000, 2'b11, rd, ok);
        chk("unmapped read", 16'h0000, rd);
    endtask : test_memory

    task automatic test_registers;
        repeat (2)
        begin
            fork
                host.access(1'b0, 17'h1FFE0, 16'h0000, 2'b11, rd, ok);
                begin
                    repeat (6) @(negedge clk);
                    chk("selected oe", 16'h0003, 16'({transferAckOe, hostDataOe}));
                end
            join
            chk("revision", 16'h003C, 16'(rd[7:0]));
            chk("idle oe", 16'h0000, 16'({transferAckOe, hostDataOe}));
        end
        host.access(1'b1, 17'h1FFE4, 16'h00C3, 2'b11, rd, ok);
        host.access(1'b0, 17'h1FFE4, 16'h0000, 2'b11, rd, ok);
        chk("scratch", 16'h00C3, 16'(rd[7:0]));
    endtask : test_registers

    task automatic test_stall;
        refreshBusy = 1'b1;
        t0 = cyc;
        fork
            host.access(1'b0, 17'h13FFE, 16'h0000, 2'b11, rd, ok);
            begin
                repeat (15) @(negedge clk);
                refreshBusy = 1'b0;
            end
        join
        chk("stalled read done", 16'h0F1E, ok ? rd : 16'hFFFF);
        chk("stall held", 16'h0001, 16'(ackCyc - t0 >= 16));
    endtask : test_stall

    task automatic test_freeze;
        t0 = cyc;
        fork
            host.access(1'b0, 17'h1FFE0, 16'h0000, 2'b11, rd, ok);
            begin
                repeat (4) @(negedge clk);
                clkEn = 1'b0;
                repeat (10) @(negedge clk);
                clkEn = 1'b1;
            end
        join
        chk("frozen read", 16'h003C, ok ? 16'(rd[7:0]) : 16'hFFFF);
        chk("freeze delay", 16'h0001, 16'(ackCyc - t0 >= 16));
    endtask : test_freeze

    task automatic test_refused;
        reset_with(5'b0_111_1);
        chk("genericMode off", 16'h0000, 16'(genericMode));
        fork
            host.access(1'b0, 17'h1FFE0, 16'h0000, 2'b11, rd, ok);
            begin
                repeat (6) @(negedge clk);
                chk("refused oe", 16'h0000, 16'({transferAckOe, hostDataOe}));
            end
        join
        chk("refused ack", 16'h0000, 16'(ok));
    endtask : test_refused

    task automatic test_big;
        reset_with(5'b1_111_0);
        chk("bigEndian on", 16'h0003, 16'({bigEndian, genericMode}));
        host.access(1'b0, 17'h1FFE0, 16'h0000, 2'b11, rd, ok);
        chk("swapped revision", 16'h003C, 16'(rd[15:8]));
        host.access(1'b1, 17'h00002, 16'h1234, 2'b11, rd, ok);
        host.access(1'b0, 17'h00002, 16'h0000, 2'b11, rd, ok);
        chk("big round trip", 16'h1234, rd);
        // Memory keeps its contents over reset, so the lane order shows
        reset_with(5'b0_111_0);
        host.access(1'b0, 17'h00002, 16'h0000, 2'b11, rd, ok);
        chk("big lane order", 16'h3412, rd);
    endtask : test_big

    task automatic finish_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    initial
    begin
        test_straps();
        test_memory();
        test_registers();
        test_stall();
        test_freeze();
        test_refused();
        test_big();
        finish_test();
    end
endmodule : hbsm_host_port_test

/* verilog/hbsm_defines.svh */
// Offsets, field positions and timing counts of the host bus strap and map block
`ifndef HBSM_DEFINES_SVH
`define HBSM_DEFINES_SVH
`define HBSM_ADDR_W 17
`define HBSM_MEM_LIMIT 17'h14000
`define HBSM_REG_BASE 17'h1FFE0
`define HBSM_REG_REV 5'h00
`define HBSM_REG_STRAP 5'h02
`define HBSM_REG_SCRATCH 5'h04
`define HBSM_STRAP_ORDER_BIT 0
`define HBSM_STRAP_GEN_BIT 1
`define HBSM_STRAP_RAW_LSB 2
`define HBSM_MEM_LAT_NS 30
`define HBSM_CLK_NS 10
`define HBSM_MEM_LAT_CYC ((`HBSM_MEM_LAT_NS + `HBSM_CLK_NS - 1) / `HBSM_CLK_NS)
`endif

/* verilog/hbsm_host_port.sv */
// Host port of the display controller: straps, address map, stall and registers
//
// What this block does
// - Capture four config straps plus bus-start at reset release
// - Byte-order strap: low little, high big endian
// - All select high, start low: generic 16-bit
// - Stall presented active high as acknowledge
// - 128K segment, lowest 80K is display memory
// - Control registers in top 32 bytes
// - Revision read at 1FFE0, no side effects
// - Stall held until data ready or accepted
`timescale 1ns/1ps
`include "hbsm_defines.svh"
module hbsm_host_port #(
    parameter int MEM_BYTES = 81920,
    parameter logic [7:0] REV_CODE = 8'h5A, // Arbitrary value
    parameter int MEM_LAT = `HBSM_MEM_LAT_CYC
) (
    // Clocking
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clkEn,
    // Strap pins
    input wire logic byteOrderStrap,
    input wire logic busSelectStrap2,
    input wire logic busSelectStrap1,
    input wire logic busSelectStrap0,
    input wire logic busStartStrap_n,
    // Host bus pins
    input wire logic chipSel_n,
    input wire logic [16:0] hostAddr,
    input wire logic [15:0] hostDataIn,
    output logic [15:0] hostDataOut,
    output logic hostDataOe,
    input wire logic lowByteWriteStrobe_n,
    input wire logic highByteWriteStrobe_n,
    input wire logic lowByteReadStrobe_n,
    input wire logic highByteReadStrobe_n,
    output logic transferAck,
    output logic transferAckOe,
    // Display refresh contention
    input wire logic refreshBusy,
    // Configuration outputs
    output logic bigEndian,
    output logic genericMode
);
    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic [4:0] strapSync;
    logic [21:0] busSync;
    logic cs, we0, we1, rd0, rd1;
    logic [16:0] addr;
    logic [15:0] din;

    hbsm_sync #(.W(5), .INIT(5'h00)) uStrapSync (
        .clk(clk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .asyncIn({byteOrderStrap, busSelectStrap2, busSelectStrap1,
            busSelectStrap0, busStartStrap_n}),
        .syncOut(strapSync)
    );

    // Address and data share the strobes' delay so they line up
    // Reset to idle levels so no false select follows reset
    hbsm_sync #(.W(22), .INIT(22'h000000)) uBusSync (
        .clk(clk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .asyncIn({~chipSel_n, ~lowByteWriteStrobe_n, ~highByteWriteStrobe_n,
            ~lowByteReadStrobe_n, ~highByteReadStrobe_n, hostAddr}),
        .syncOut(busSync)
    );
    logic [15:0] dinSync;
    hbsm_sync #(.W(16), .INIT(16'h0000)) uDataSync (
        .clk(clk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .asyncIn(hostDataIn),
        .syncOut(dinSync)
    );
    assign cs = busSync[21];
    assign we0 = busSync[20];
    assign we1 = busSync[19];
    assign rd0 = busSync[18];
    assign rd1 = busSync[17];
    assign addr = busSync[16:0];
    assign din = dinSync;

    // ************************************************
    // Strap capture
    // ************************************************
    // Synchronised straps reach valid value two edges after release
    logic [1:0] capCnt_q;
    logic captured_q;
    logic [4:0] strap_q;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            capCnt_q <= 2'h0;
            captured_q <= 1'b0;
            strap_q <= 5'h00;
        end
        else if (clkEn && !captured_q)
        begin
            capCnt_q <= capCnt_q + 2'h1;
            if (capCnt_q == 2'h2)
            begin
                strap_q <= strapSync;
                captured_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            bigEndian <= 1'b0;
            genericMode <= 1'b0;
        end
        else if (clkEn && capCnt_q == 2'h2 && !captured_q)
        begin
            bigEndian <= strapSync[4];
            genericMode <= (strapSync[3:1] == 3'h7) && !strapSync[0];
        end
    end

    // ************************************************
    // Address map
    // ************************************************
    hbsm_pkg::hbsm_map_t region;
    always_comb
    begin
        if (addr < `HBSM_MEM_LIMIT)
            region = hbsm_pkg::HBSM_MAP_MEM;
        else if (addr >= `HBSM_REG_BASE)
            region = hbsm_pkg::HBSM_MAP_REG;
        else
            region = hbsm_pkg::HBSM_MAP_NONE;
    end

    // Byte lanes swap in big-endian so the low address byte lands high
    logic [15:0] wrData;
    logic wrLo, wrHi;
    assign wrData = bigEndian ? {din[7:0], din[15:8]} : din;
    assign wrLo = bigEndian ? we1 : we0;
    assign wrHi = bigEndian ? we0 : we1;

    // ************************************************
    // Display memory and registers
    // ************************************************
    logic [15:0] mem [MEM_BYTES/2];
    logic [7:0] scratch_q;
    logic [15:0] rdWord;
    logic [4:0] regOff;
    assign regOff = {addr[4:1], 1'b0};

    // ************************************************
    // Access sequencer
    // ************************************************
    hbsm_pkg::hbsm_state_t state_q;
    logic [7:0] latCnt_q;
    logic active;
    assign active = cs && genericMode && (we0 || we1 || rd0 || rd1);

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state_q <= hbsm_pkg::HBSM_IDLE;
            latCnt_q <= 8'h00;
        end
        else if (clkEn)
        begin
            case (state_q)
                hbsm_pkg::HBSM_IDLE:
                    if (active)
                    begin
                        state_q <= hbsm_pkg::HBSM_BUSY;
                        latCnt_q <= 8'(MEM_LAT);
                    end
                hbsm_pkg::HBSM_BUSY:
                    // Refresh owns memory; host waits for arbitration
                    if (!refreshBusy && latCnt_q <= 8'h1)
                        state_q <= hbsm_pkg::HBSM_DONE;
                    else if (latCnt_q > 8'h1)
                        latCnt_q <= latCnt_q - 8'h1;
                hbsm_pkg::HBSM_DONE:
                    if (!active)
                        state_q <= hbsm_pkg::HBSM_IDLE;
                default:
                    state_q <= hbsm_pkg::HBSM_IDLE;
            endcase
        end
    end

    logic commit;
    assign commit = clkEn && state_q == hbsm_pkg::HBSM_BUSY && !refreshBusy
        && latCnt_q <= 8'h1;

    always_ff @(posedge clk)
    begin
        if (commit && (we0 || we1) && region == hbsm_pkg::HBSM_MAP_MEM)
        begin
            if (wrLo)
                mem[addr[16:1]][7:0] <= wrData[7:0];
            if (wrHi)
                mem[addr[16:1]][15:8] <= wrData[15:8];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            scratch_q <= 8'h00;
        else if (commit && (we0 || we1) && region == hbsm_pkg::HBSM_MAP_REG
            && regOff == `HBSM_REG_SCRATCH && wrLo)
            scratch_q <= wrData[7:0];
    end

    always_comb
    begin
        rdWord = 16'h0000;
        if (region == hbsm_pkg::HBSM_MAP_MEM)
            rdWord = mem[addr[16:1]];
        else if (region == hbsm_pkg::HBSM_MAP_REG)
        begin
            case (regOff)
                `HBSM_REG_REV: rdWord = {8'h00, REV_CODE};
                `HBSM_REG_STRAP: rdWord = {8'h00, 1'b0, strap_q, genericMode, bigEndian};
                `HBSM_REG_SCRATCH: rdWord = {8'h00, scratch_q};
                default: rdWord = 16'h0000;
            endcase
        end
    end

    // ************************************************
    // Pin outputs
    // ************************************************
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            hostDataOut <= 16'h0000;
            hostDataOe <= 1'b0;
        end
        else if (clkEn)
        begin
            if (commit && (rd0 || rd1))
                hostDataOut <= bigEndian ? {rdWord[7:0], rdWord[15:8]} : rdWord;
            hostDataOe <= cs && (rd0 || rd1) && genericMode;
        end
    end

    // Acknowledge only driven while selected so other devices share the line
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            transferAck <= 1'b0;
            transferAckOe <= 1'b0;
        end
        else if (clkEn)
        begin
            transferAck <= commit;
            transferAckOe <= cs && genericMode;
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    property p_strapFrozen;
        @(posedge clk) disable iff (!rst_b)
        (captured_q && clkEn) |=> $stable(strap_q);
    endproperty
    a_strapFrozen: assert property (p_strapFrozen) else $error("strap changed");

    property p_genDecode;
        @(posedge clk) disable iff (!rst_b)
        captured_q |-> genericMode == (strap_q[3:1] == 3'h7 && !strap_q[0]);
    endproperty
    a_genDecode: assert property (p_genDecode) else $error("mode decode wrong");

    property p_endian;
        @(posedge clk) disable iff (!rst_b)
        captured_q |-> bigEndian == strap_q[4];
    endproperty
    a_endian: assert property (p_endian) else $error("byte order wrong");

    property p_captureTime;
        @(posedge clk) disable iff (!rst_b)
        ($rose(rst_b) ##0 clkEn [*4]) |-> captured_q;
    endproperty
    a_captureTime: assert property (p_captureTime) else $error("straps not caught");

    property p_noAckInRefresh;
        @(posedge clk) disable iff (!rst_b)
        (clkEn && refreshBusy) |=> !transferAck;
    endproperty
    a_noAckInRefresh: assert property (p_noAckInRefresh) else $error("ack in refresh");

    property p_ackOnePulse;
        @(posedge clk) disable iff (!rst_b)
        (transferAck && clkEn) |=> !transferAck;
    endproperty
    a_ackOnePulse: assert property (p_ackOnePulse) else $error("ack held");

    property p_regRegion;
        @(posedge clk) disable iff (!rst_b)
        (addr >= 17'h1FFE0) |-> region == hbsm_pkg::HBSM_MAP_REG;
    endproperty
    a_regRegion: assert property (p_regRegion) else $error("reg decode wrong");

    property p_memRegion;
        @(posedge clk) disable iff (!rst_b)
        (addr < 17'h14000) |-> region == hbsm_pkg::HBSM_MAP_MEM;
    endproperty
    a_memRegion: assert property (p_memRegion) else $error("mem decode wrong");

    property p_revRead;
        @(posedge clk) disable iff (!rst_b)
        (commit && rd0 && addr == 17'h1FFE0 && !bigEndian) |=> hostDataOut[7:0] == REV_CODE;
    endproperty
    a_revRead: assert property (p_revRead) else $error("revision wrong");
endmodule : hbsm_host_port

/* verilog/hbsm_pkg.sv */
// Types shared by the host bus strap and map block
package hbsm_pkg;
    typedef enum logic [1:0] {
        HBSM_IDLE = 2'b00,
        HBSM_BUSY = 2'b01,
        HBSM_DONE = 2'b10
    } hbsm_state_t;
    typedef enum logic [1:0] {
        HBSM_MAP_MEM = 2'b00,
        HBSM_MAP_REG = 2'b01,
        HBSM_MAP_NONE = 2'b10
    } hbsm_map_t;
endpackage : hbsm_pkg

/* verilog/hbsm_sync.sv */
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module hbsm_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clocking
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clkEn,
    // Data
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            meta_q <= INIT;
            syncOut <= INIT;
        end
        else if (clkEn)
        begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule : hbsm_sync
